// ===== rtl/bcpm_pkg.sv
/*
 Package for the bridge control upper half and power management capability bank.
 Assumes a 32-bit AHB-Lite register bus and a single core clock.
*/
package bcpm_pkg;
  localparam logic [31:0] BCPM_OFS_BRIDGE_CTRL = 32'h0000003C;
  localparam logic [31:0] BCPM_OFS_PM_CAP = 32'h00000040;
  localparam logic [31:0] BCPM_OFS_DFLT_LOAD = 32'h00000080;
  // Bridge control bit positions within the 32-bit word
  localparam int BCPM_BIT_VGA16 = 20;
  localparam int BCPM_BIT_SEC_RST = 22;
  // Power_mgmt_capability field positions
  localparam int BCPM_POS_CAP_ID = 0;
  localparam int BCPM_POS_NEXT_PTR = 8;
  localparam int BCPM_POS_PM_REV = 16;
  localparam int BCPM_POS_DSI = 21;
  localparam int BCPM_POS_AUX = 22;
  localparam int BCPM_POS_D1 = 25;
  localparam int BCPM_POS_D2 = 26;
  localparam int BCPM_POS_PME = 27;
  // Fixed and reset values
  localparam logic [7:0] BCPM_CAP_ID = 8'h01;
  localparam logic [7:0] BCPM_NEXT_UP = 8'h5C;
  localparam logic [7:0] BCPM_NEXT_DN = 8'h4C;
  localparam logic [2:0] BCPM_PM_REV = 3'h3;
  localparam logic BCPM_RST_DSI = 1'b0;
  localparam logic [2:0] BCPM_RST_AUX = 3'h7;
  localparam logic BCPM_RST_D1 = 1'b1;
  localparam logic BCPM_RST_D2 = 1'b1;
  localparam logic [4:0] BCPM_RST_PME = 5'h1F;
  localparam logic BCPM_RST_VGA16 = 1'b0;
  localparam logic BCPM_RST_SEC_RST = 1'b0;
  // AHB encodings
  localparam logic [1:0] BCPM_HTRANS_NONSEQ = 2'h2;

  // Capability defaults loaded by the side-band loader
  typedef struct packed {
    logic [4:0] pme;
    logic d2;
    logic d1;
    logic [2:0] aux;
    logic dsi;
  } bcpm_cap_dflt_t;

  // Latched AHB address phase
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } bcpm_aphase_t;
endpackage : bcpm_pkg

// ===== rtl/bcpm_regs.sv
/*
 Bridge control upper half and power management capability register bank.
 Assumes an AHB-Lite master on i_clock, side-band default loader on the same clock.
*/
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/1ps
module bcpm_regs #(
  parameter bit IS_UPSTREAM = 1'b1,
  parameter int NUM_DOWN = 2
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  input wire logic i_dflt_load,
  input wire bcpm_pkg::bcpm_cap_dflt_t i_dflt,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic o_vga_decode_16,
  output logic [NUM_DOWN-1:0] o_port_rst
);

  ////////////////////////////////////////////////////////////////////////////
  bcpm_pkg::bcpm_aphase_t aph_reg;
  logic vga16_reg;
  logic sec_rst_reg;
  bcpm_pkg::bcpm_cap_dflt_t cap_reg;
  logic [7:0] next_ptr_reg;
  logic wr_en;
  logic ctl_wr;

  function automatic logic [31:0] pm_cap_word(input bcpm_pkg::bcpm_cap_dflt_t c,
                                              input logic [7:0] nptr);
    logic [31:0] w;
    w = 32'h00000000;
    w[bcpm_pkg::BCPM_POS_CAP_ID +: 8] = bcpm_pkg::BCPM_CAP_ID;
    w[bcpm_pkg::BCPM_POS_NEXT_PTR +: 8] = nptr;
    w[bcpm_pkg::BCPM_POS_PM_REV +: 3] = bcpm_pkg::BCPM_PM_REV;
    w[bcpm_pkg::BCPM_POS_DSI] = c.dsi;
    w[bcpm_pkg::BCPM_POS_AUX +: 3] = c.aux;
    w[bcpm_pkg::BCPM_POS_D1] = c.d1;
    w[bcpm_pkg::BCPM_POS_D2] = c.d2;
    w[bcpm_pkg::BCPM_POS_PME +: 5] = c.pme;
    return w;
  endfunction : pm_cap_word

  ////////////////////////////////////////////////////////////////////////////
  // Zero wait state slave; response is always OKAY
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      aph_reg <= '0;
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
    end
    else if (i_hready)
    begin
      aph_reg.valid <= i_hsel && (i_htrans == bcpm_pkg::BCPM_HTRANS_NONSEQ);
      aph_reg.write <= i_hwrite;
      aph_reg.addr <= i_haddr[7:0];
    end
  end

  assign wr_en = aph_reg.valid && aph_reg.write;
  assign ctl_wr = wr_en && (aph_reg.addr == bcpm_pkg::BCPM_OFS_BRIDGE_CTRL[7:0]);

  // Read data registered at the address phase so it stands in the data phase
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
      o_hrdata <= 32'h00000000;
    else if (i_hready && i_hsel && !i_hwrite && (i_htrans == bcpm_pkg::BCPM_HTRANS_NONSEQ))
    begin
      unique case (i_haddr[7:0])
        bcpm_pkg::BCPM_OFS_BRIDGE_CTRL[7:0]:
        begin
          // Legacy bits 21, 23..27 and reserved bits read zero
          o_hrdata <= 32'h00000000;
          // A read right behind a write sees the word still in its data phase
          o_hrdata[bcpm_pkg::BCPM_BIT_VGA16] <= ctl_wr ? i_hwdata[bcpm_pkg::BCPM_BIT_VGA16]
                                                       : vga16_reg;
          o_hrdata[bcpm_pkg::BCPM_BIT_SEC_RST] <= ctl_wr ? i_hwdata[bcpm_pkg::BCPM_BIT_SEC_RST]
                                                         : sec_rst_reg;
        end
        bcpm_pkg::BCPM_OFS_PM_CAP[7:0]:
          o_hrdata <= pm_cap_word(cap_reg, next_ptr_reg);
        default:
          o_hrdata <= 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bridge control: only bits 20 and 22 are writable; the rest are dropped
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      vga16_reg <= bcpm_pkg::BCPM_RST_VGA16;
      sec_rst_reg <= bcpm_pkg::BCPM_RST_SEC_RST;
    end
    else if (wr_en && aph_reg.addr == bcpm_pkg::BCPM_OFS_BRIDGE_CTRL[7:0])
    begin
      vga16_reg <= i_hwdata[bcpm_pkg::BCPM_BIT_VGA16];
      sec_rst_reg <= i_hwdata[bcpm_pkg::BCPM_BIT_SEC_RST];
    end
  end

  // Decode width select: 1 = 16 address bits, 0 = 10 address bits
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
      o_vga_decode_16 <= 1'b0;
    else
      o_vga_decode_16 <= vga16_reg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Port resets: a downstream instance drives its single port, upstream drives all
  genvar gi;
  generate
    for (gi = 0; gi < NUM_DOWN; gi++)
    begin : g_port_rst
      always_ff @(posedge i_clock)
      begin
        if (i_rst)
          o_port_rst[gi] <= 1'b0;
        else if (IS_UPSTREAM || gi == 0)
          o_port_rst[gi] <= sec_rst_reg;
        else
          o_port_rst[gi] <= 1'b0;
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Capability defaults: RO to software but reloadable by SMBus/EEPROM loader
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      cap_reg.dsi <= bcpm_pkg::BCPM_RST_DSI;
      cap_reg.aux <= bcpm_pkg::BCPM_RST_AUX;
      cap_reg.d1 <= bcpm_pkg::BCPM_RST_D1;
      cap_reg.d2 <= bcpm_pkg::BCPM_RST_D2;
      cap_reg.pme <= bcpm_pkg::BCPM_RST_PME;
    end
    else if (i_dflt_load)
      cap_reg <= i_dflt;
  end

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
      next_ptr_reg <= IS_UPSTREAM ? bcpm_pkg::BCPM_NEXT_UP : bcpm_pkg::BCPM_NEXT_DN;
  end

  ////////////////////////////////////////////////////////////////////////////
  a_vga_follow: assert property (@(posedge i_clock) disable iff (i_rst)
    (wr_en && aph_reg.addr == bcpm_pkg::BCPM_OFS_BRIDGE_CTRL[7:0]) |=>
      ##1 o_vga_decode_16 == $past(i_hwdata[bcpm_pkg::BCPM_BIT_VGA16], 2))
    else $error("vga decode width not following write");
  a_vga_narrow: assert property (@(posedge i_clock) disable iff (i_rst)
    !vga16_reg |=> !o_vga_decode_16)
    else $error("10-bit decode not selected");
  a_rst_hold: assert property (@(posedge i_clock) disable iff (i_rst)
    sec_rst_reg && $past(sec_rst_reg) |-> o_port_rst[0])
    else $error("port reset dropped while bit set");
  a_rst_clear: assert property (@(posedge i_clock) disable iff (i_rst)
    !sec_rst_reg |=> o_port_rst == '0)
    else $error("port reset with bit clear");
  a_up_all: assert property (@(posedge i_clock) disable iff (i_rst)
    IS_UPSTREAM && sec_rst_reg |=> &o_port_rst)
    else $error("upstream reset not on all ports");
  a_dn_one: assert property (@(posedge i_clock) disable iff (i_rst)
    !IS_UPSTREAM && sec_rst_reg |=> o_port_rst[0])
    else $error("downstream reset not driven");
  a_legacy_zero: assert property (@(posedge i_clock) disable iff (i_rst)
    (aph_reg.valid && !aph_reg.write
     && aph_reg.addr == bcpm_pkg::BCPM_OFS_BRIDGE_CTRL[7:0])
      |-> (o_hrdata[27:23] == 5'h00 && !o_hrdata[21]))
    else $error("legacy bridge bit nonzero");
  a_cap_fixed: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_hready && i_hsel && !i_hwrite && i_htrans == bcpm_pkg::BCPM_HTRANS_NONSEQ
     && i_haddr[7:0] == bcpm_pkg::BCPM_OFS_PM_CAP[7:0])
      |=> (o_hrdata[7:0] == 8'h01 && o_hrdata[18:16] == 3'h3 && !o_hrdata[19]))
    else $error("cap id or revision wrong");
  a_next_ptr: assert property (@(posedge i_clock) disable iff (i_rst)
    next_ptr_reg == (IS_UPSTREAM ? 8'h5C : 8'h4C))
    else $error("next pointer wrong");
  a_dflt_load: assert property (@(posedge i_clock) disable iff (i_rst)
    i_dflt_load |=> cap_reg == $past(i_dflt))
    else $error("default load not taken");
  a_dflt_keep: assert property (@(posedge i_clock) disable iff (i_rst)
    !i_dflt_load |=> $stable(cap_reg))
    else $error("capability defaults changed without load");
  a_reset_vals: assert property (@(posedge i_clock)
    i_rst |=> (cap_reg.pme == 5'h1F && cap_reg.aux == 3'h7 && cap_reg.d1 && cap_reg.d2
               && !cap_reg.dsi))
    else $error("capability reset values wrong");
  a_okay: assert property (@(posedge i_clock) disable iff (i_rst)
    o_hreadyout && !o_hresp)
    else $error("slave not ready or not OKAY");

  c_sbr_set: cover property (@(posedge i_clock) disable iff (i_rst)
    !sec_rst_reg ##1 sec_rst_reg ##[1:20] !sec_rst_reg);
  c_vga16: cover property (@(posedge i_clock) disable iff (i_rst) $rose(o_vga_decode_16));
  c_load: cover property (@(posedge i_clock) disable iff (i_rst) i_dflt_load);
  c_cap_read: cover property (@(posedge i_clock) disable iff (i_rst)
    aph_reg.valid && !aph_reg.write && aph_reg.addr == bcpm_pkg::BCPM_OFS_PM_CAP[7:0]);

endmodule : bcpm_regs

// ===== tb/bcpm_regs_tb.sv
/*
 Self-checking bench for the bridge control and power management capability bank.
 Assumes the upstream defaults of the bank and a zero-wait AHB-Lite slave.
*/
`timescale 1ns/1ps
module bcpm_regs_tb;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic i_hsel = 1'b0;
  logic i_hwrite = 1'b0;
  logic i_dflt_load = 1'b0;
  logic [31:0] i_haddr = 32'h0;
  logic [31:0] i_hwdata = 32'h0;
  logic [1:0] i_htrans = 2'h0;
  logic [2:0] i_hsize = 3'h2;
  bcpm_pkg::bcpm_cap_dflt_t i_dflt = '0;
  logic [31:0] o_hrdata;
  logic o_hreadyout;
  logic o_hresp;
  logic o_vga_decode_16;
  logic [1:0] o_port_rst;
  logic [1:0] dn_port_rst;
  logic dn_hreadyout;
  logic [31:0] exp_q[$];
  logic rd_dph = 1'b0;
  logic [31:0] seed = 32'h0000DDC1;
  logic [31:0] v;
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;
  bcpm_regs i_bcpm_regs (.i_clock(i_clock), .i_rst(i_rst), .i_hsel(i_hsel), .i_haddr(i_haddr),
    .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata),
    .i_hready(o_hreadyout), .i_dflt_load(i_dflt_load), .i_dflt(i_dflt), .o_hrdata(o_hrdata),
    .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_vga_decode_16(o_vga_decode_16),
    .o_port_rst(o_port_rst));
  // Downstream copy on the same bus lines: only its reset fan-out is compared
  bcpm_regs #(.IS_UPSTREAM(1'b0), .NUM_DOWN(2)) i_bcpm_regs_dn (.i_clock(i_clock),
    .i_rst(i_rst), .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans),
    .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata), .i_hready(dn_hreadyout),
    .i_dflt_load(i_dflt_load), .i_dflt(i_dflt), .o_hrdata(), .o_hreadyout(dn_hreadyout),
    .o_hresp(), .o_vga_decode_16(), .o_port_rst(dn_port_rst));
  initial
  begin
    forever #12.5 i_clock = ~i_clock;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", name, e, g);
    end
  endtask : chk
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  task automatic rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    v = seed;
  endtask : rnd
  // Called just after a rising edge; returns at the edge ending the data phase
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    i_hsel <= 1'b1;
    i_haddr <= a;
    i_hwrite <= w;
    i_htrans <= bcpm_pkg::BCPM_HTRANS_NONSEQ;
    do @(posedge i_clock); while (o_hreadyout !== 1'b1);
    i_htrans <= 2'h0;
    i_hwdata <= d;
    do @(posedge i_clock); while (o_hreadyout !== 1'b1);
  endtask : xfer
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    xfer(1'b0, a, 32'h0);
  endtask : rd
  // Control outputs follow the stored bit one cycle after the write lands
  task automatic wr_ctl(input logic [31:0] d);
    xfer(1'b1, bcpm_pkg::BCPM_OFS_BRIDGE_CTRL, d);
    @(posedge i_clock);
    @(posedge i_clock);
    chk("vga16", {31'h0, d[20]}, {31'h0, o_vga_decode_16});
    chk("port_rst", {30'h0, {2{d[22]}}}, {30'h0, o_port_rst});
    chk("port_rst_dn", {31'h0, d[22]}, {30'h0, dn_port_rst});
    rd(bcpm_pkg::BCPM_OFS_BRIDGE_CTRL, d & 32'h00500000);
  endtask : wr_ctl
  ////////////////////////////////////////////////////////////////////////////////
  // Watcher: compares each read's data phase against the oldest note
  always @(posedge i_clock)
  begin
    cyc <= cyc + 1;
    if (cyc > 5000)
    begin
      n_mismatch++;
      finish_test();
    end
    if (rd_dph && o_hreadyout === 1'b1)
    begin
      chk("hrdata", exp_q.pop_front(), o_hrdata);
      chk("hresp", 32'h0, {31'h0, o_hresp});
    end
    rd_dph <= i_hsel && i_htrans == bcpm_pkg::BCPM_HTRANS_NONSEQ && !i_hwrite && o_hreadyout;
  end
  initial
  begin
    repeat (3) @(posedge i_clock);
    i_rst <= 1'b0;
    for (int pass = 0; pass < 2; pass++)
    begin
      rd(bcpm_pkg::BCPM_OFS_PM_CAP, 32'hFFC35C01);
      rd(bcpm_pkg::BCPM_OFS_BRIDGE_CTRL, 32'h0);
      chk("port_rst_rst", 32'h0, {30'h0, o_port_rst});
      wr_ctl(32'hFFFFFFFF);
      xfer(1'b1, bcpm_pkg::BCPM_OFS_PM_CAP, 32'h0);
      rd(bcpm_pkg::BCPM_OFS_PM_CAP, 32'hFFC35C01);
      xfer(1'b1, 32'h00000080, 32'h0);
      rd(32'h00000080, 32'h0);
      for (int k = 0; k < 4; k++)
      begin
        rnd();
        wr_ctl(v);
        rnd();
        i_dflt <= v[10:0];
        i_dflt_load <= 1'b1;
        @(posedge i_clock);
        i_dflt_load <= 1'b0;
        rd(bcpm_pkg::BCPM_OFS_PM_CAP, {v[10:0], 5'h03, 8'h5C, 8'h01});
      end
      wr_ctl(32'h00400000);
      i_rst <= 1'b1;
      @(posedge i_clock);
      i_rst <= 1'b0;
    end
    wr_ctl(32'h0);
    finish_test();
  end
endmodule : bcpm_regs_tb
